// File: rtl/tcc_timer16.sv
// 16-bit timer compare, capture and interrupt flag/mask register block
// Notes on behaviour
// [RQ1] Three 16-bit compare values are compared with the counter continuously.
// [RQ2] High byte writes stage in one shared latch; low byte write commits both.
// [RQ3] Capture low byte read copies matching high byte into shared latch.
// [RQ4] Capture loads counter on qualified pin event, or comparator output option.
// [RQ5] Capture flag sets on each capture event.
// [RQ6] With capture as ceiling, capture flag sets when counter hits ceiling.
// [RQ7] Mask bit 5 gates capture request with global enable and flag.
// [RQ8] Mask bits 3,2,1 gate compare C,B,A requests with global enable.
// [RQ9] Mask bit 0 gates overflow request with global enable and flag.
// [RQ10] Compare flag sets one timer clock after counter equals compare value.
// [RQ11] Force-compare strobes never set compare flags.
// [RQ12] Vector execution acknowledges clear the matching flag.
// [RQ13] Writing one to a flag bit clears it; zero leaves it.
// [RQ14] Normal and clear-on-match modes set overflow at counter overflow.
// [RQ15] PWM modes set overflow at ceiling or bottom per mode lookup.
// [RQ16] Edge select zero picks falling, one picks rising capture edge.
// [RQ17] Noise filter needs four equal samples, delaying capture four clocks.
// [RQ18] Counter write blocks compare matches on the following timer clock.
`timescale 1ns/1ps
module tcc_timer16
  import tcc_pkg::*;
#(
  parameter int FILTER_LEN = FILT_LEN
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // Register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Counter core
  input  wire logic [15:0] COUNTER_VALUE,
  input  wire logic        TIMER_TICK,
  input  wire logic        COUNT_DOWN,
  input  wire logic [2:0]  FORCE_COMPARE_STROBE,
  output logic      [3:0]  WAVEFORM_MODE_SELECT,
  output logic      [15:0] COUNTER_WRITE_VALUE,
  output logic             COUNTER_WRITE,
  output logic      [15:0] TOP_VALUE,
  output logic      [2:0]  COMPARE_MATCH,
  output logic      [2:0]  COMPARE_FORCE,
  // Capture sources
  input  wire logic        CAPTURE_PIN,
  input  wire logic        COMPARATOR_OUT,
  // Interrupt handshake
  input  wire logic        GLOBAL_IRQ_ENABLE,
  input  wire logic [4:0]  VECTOR_ACK,
  output logic      [4:0]  IRQ_REQUEST
);
  initial begin
    if (FILTER_LEN != FILT_LEN) $error("tcc_timer16: filter length must be four");
  end

  typedef struct packed {
    logic [2:0][15:0] cmp;
    logic [15:0]      cap;
    logic [7:0]       temp;
    logic [7:0]       mask;
    logic [7:0]       flags;
    logic [7:0]       ctrl;
    logic [7:0]       rdata;
    logic             block;
    logic [15:0]      cnt_wval;
    logic             cnt_wr;
    logic [2:0]       match;
    logic [2:0]       force_o;
    logic [15:0]      top;
    logic [4:0]       irq;
  } tcc_state_t;

  tcc_state_t st_r;
  tcc_state_t st_nxt;

  logic cap_pin_ev;
  logic cap_src_sel;
  logic cap_src;

  assign cap_src_sel = st_r.ctrl[CTRL_ACMP];
  assign cap_src = cap_src_sel ? COMPARATOR_OUT : CAPTURE_PIN; // [RQ4]

  tcc_capture_filter #(
    .LEN (FILTER_LEN)
  ) u_filter (
    .clk         (CLOCK),
    .rst         (RESET),
    .filt_en     (st_r.ctrl[CTRL_FILT]),
    .rise_sel    (st_r.ctrl[CTRL_EDGE]),
    .pin         (cap_src),
    .event_pulse (cap_pin_ev)
  );

  // Map acknowledge index to flag bit position
  function automatic logic [7:0] ack_to_flags(input logic [4:0] ack);
    logic [7:0] f;
    f = 8'h00;
    f[BIT_OVF]  = ack[0];
    f[BIT_CMPA] = ack[1];
    f[BIT_CMPB] = ack[2];
    f[BIT_CMPC] = ack[3];
    f[BIT_CAP]  = ack[4];
    return f;
  endfunction

  logic [3:0]  wgm;
  tcc_top_t    top_sel;
  tcc_ovf_t    ovf_sel;
  logic [15:0] top_now;
  logic [7:0]  set_flags;
  logic [7:0]  clr_flags;

  always_comb begin
    wgm = st_r.ctrl[CTRL_WGM +: 4];
    top_sel = tcc_top_src(wgm);
    ovf_sel = tcc_ovf_point(wgm);
    case (top_sel)
      TOP_CAP:  top_now = st_r.cap;
      TOP_CMPA: top_now = st_r.cmp[0];
      default:  top_now = tcc_top_value(wgm);
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    set_flags = 8'h00;
    clr_flags = ack_to_flags(VECTOR_ACK); // [RQ12]
    st_nxt.cnt_wr = 1'b0;
    st_nxt.rdata = RST_BYTE;
    st_nxt.top = top_now;
    // Force strobes act on the waveform only, outside PWM modes
    st_nxt.force_o = (ovf_sel == OVF_AT_MAX) ? FORCE_COMPARE_STROBE : 3'h0; // [RQ11]

    // Match is equality on an unblocked tick; flag lands the clock after the match tick
    for (int i = 0; i < 3; i++) begin
      st_nxt.match[i] = TIMER_TICK && !st_r.block && (COUNTER_VALUE == st_r.cmp[i]); // [RQ1]
    end
    if (st_r.match[0]) set_flags[BIT_CMPA] = 1'b1; // [RQ10]
    if (st_r.match[1]) set_flags[BIT_CMPB] = 1'b1; // [RQ10]
    if (st_r.match[2]) set_flags[BIT_CMPC] = 1'b1; // [RQ10]
    // Block holds until a timer tick has passed after a counter write
    if (TIMER_TICK) st_nxt.block = 1'b0; // [RQ18]

    // Capture: pin disconnected while capture register is the ceiling
    if (top_sel == TOP_CAP) begin
      if (TIMER_TICK && COUNTER_VALUE == st_r.cap) set_flags[BIT_CAP] = 1'b1; // [RQ6]
    end else if (cap_pin_ev) begin
      st_nxt.cap = COUNTER_VALUE; // [RQ4]
      set_flags[BIT_CAP] = 1'b1; // [RQ5]
    end

    // Overflow point by mode
    if (TIMER_TICK) begin
      case (ovf_sel)
        OVF_AT_MAX:    set_flags[BIT_OVF] = (COUNTER_VALUE == CNT_MAX); // [RQ14]
        OVF_AT_TOP:    set_flags[BIT_OVF] = (COUNTER_VALUE == top_now); // [RQ15]
        OVF_AT_BOTTOM: set_flags[BIT_OVF] = COUNT_DOWN && (COUNTER_VALUE == CNT_BOT); // [RQ15]
        default:       set_flags[BIT_OVF] = 1'b0;
      endcase
    end

    if (WR) begin
      if (ADDR == ADDR_CMPA_HI || ADDR == ADDR_CMPB_HI || ADDR == ADDR_CMPC_HI ||
          ADDR == ADDR_CAP_HI || ADDR == ADDR_CNT_HI) begin
        st_nxt.temp = WDATA; // [RQ2]
      end else if (ADDR == ADDR_CMPA_LO) begin
        st_nxt.cmp[0] = {st_r.temp, WDATA}; // [RQ2]
      end else if (ADDR == ADDR_CMPB_LO) begin
        st_nxt.cmp[1] = {st_r.temp, WDATA}; // [RQ2]
      end else if (ADDR == ADDR_CMPC_LO) begin
        st_nxt.cmp[2] = {st_r.temp, WDATA}; // [RQ2]
      end else if (ADDR == ADDR_CAP_LO) begin
        st_nxt.cap = {st_r.temp, WDATA}; // [RQ2]
      end else if (ADDR == ADDR_CNT_LO) begin
        st_nxt.cnt_wval = {st_r.temp, WDATA}; // [RQ2]
        st_nxt.cnt_wr = 1'b1;
        st_nxt.block = 1'b1; // [RQ18]
        st_nxt.match = 3'h0; // [RQ18]
      end else if (ADDR == ADDR_MASK) begin
        st_nxt.mask = WDATA & FLAG_USED;
      end else if (ADDR == ADDR_FLAGS) begin
        clr_flags = clr_flags | (WDATA & FLAG_USED); // [RQ13]
      end else if (ADDR == ADDR_CTRL) begin
        st_nxt.ctrl = {WDATA[7:5], 1'b0, WDATA[3:0]};
      end
    end

    if (RD) begin
      if (ADDR == ADDR_CMPA_LO) begin
        st_nxt.rdata = st_r.cmp[0][7:0];
      end else if (ADDR == ADDR_CMPA_HI) begin
        st_nxt.rdata = st_r.cmp[0][15:8];
      end else if (ADDR == ADDR_CMPB_LO) begin
        st_nxt.rdata = st_r.cmp[1][7:0];
      end else if (ADDR == ADDR_CMPB_HI) begin
        st_nxt.rdata = st_r.cmp[1][15:8];
      end else if (ADDR == ADDR_CMPC_LO) begin
        st_nxt.rdata = st_r.cmp[2][7:0];
      end else if (ADDR == ADDR_CMPC_HI) begin
        st_nxt.rdata = st_r.cmp[2][15:8];
      end else if (ADDR == ADDR_CAP_LO) begin
        st_nxt.rdata = st_r.cap[7:0];
        st_nxt.temp = st_r.cap[15:8]; // [RQ3]
      end else if (ADDR == ADDR_CAP_HI) begin
        st_nxt.rdata = st_r.temp; // [RQ3]
      end else if (ADDR == ADDR_CNT_LO) begin
        st_nxt.rdata = COUNTER_VALUE[7:0];
        st_nxt.temp = COUNTER_VALUE[15:8];
      end else if (ADDR == ADDR_CNT_HI) begin
        st_nxt.rdata = st_r.temp;
      end else if (ADDR == ADDR_MASK) begin
        st_nxt.rdata = st_r.mask;
      end else if (ADDR == ADDR_FLAGS) begin
        st_nxt.rdata = st_r.flags;
      end else if (ADDR == ADDR_CTRL) begin
        st_nxt.rdata = st_r.ctrl;
      end else begin
        st_nxt.rdata = RST_BYTE;
      end
    end

    // A new event outranks a clear in the same cycle
    st_nxt.flags = ((st_r.flags & ~clr_flags) | set_flags) & FLAG_USED; // [RQ13]

    // Requests follow the registered flags and mask
    st_nxt.irq[0] = GLOBAL_IRQ_ENABLE & st_r.mask[BIT_OVF]  & st_r.flags[BIT_OVF];  // [RQ9]
    st_nxt.irq[1] = GLOBAL_IRQ_ENABLE & st_r.mask[BIT_CMPA] & st_r.flags[BIT_CMPA]; // [RQ8]
    st_nxt.irq[2] = GLOBAL_IRQ_ENABLE & st_r.mask[BIT_CMPB] & st_r.flags[BIT_CMPB]; // [RQ8]
    st_nxt.irq[3] = GLOBAL_IRQ_ENABLE & st_r.mask[BIT_CMPC] & st_r.flags[BIT_CMPC]; // [RQ8]
    st_nxt.irq[4] = GLOBAL_IRQ_ENABLE & st_r.mask[BIT_CAP]  & st_r.flags[BIT_CAP];  // [RQ7]
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA                = st_r.rdata;
  assign WAVEFORM_MODE_SELECT = st_r.ctrl[CTRL_WGM +: 4];
  assign COUNTER_WRITE_VALUE  = st_r.cnt_wval;
  assign COUNTER_WRITE        = st_r.cnt_wr;
  assign TOP_VALUE            = st_r.top;
  assign COMPARE_MATCH        = st_r.match;
  assign COMPARE_FORCE        = st_r.force_o;
  assign IRQ_REQUEST          = st_r.irq;
endmodule

// File: rtl/tcc_pkg.sv
// Constants and types shared by the timer compare/capture block
package tcc_pkg;
  // Register byte addresses on the plain register port
  localparam logic [3:0] ADDR_CMPA_LO  = 4'h0;
  localparam logic [3:0] ADDR_CMPA_HI  = 4'h1;
  localparam logic [3:0] ADDR_CMPB_LO  = 4'h2;
  localparam logic [3:0] ADDR_CMPB_HI  = 4'h3;
  localparam logic [3:0] ADDR_CMPC_LO  = 4'h4;
  localparam logic [3:0] ADDR_CMPC_HI  = 4'h5;
  localparam logic [3:0] ADDR_CAP_LO   = 4'h6;
  localparam logic [3:0] ADDR_CAP_HI   = 4'h7;
  localparam logic [3:0] ADDR_MASK     = 4'h8;
  localparam logic [3:0] ADDR_FLAGS    = 4'h9;
  localparam logic [3:0] ADDR_CTRL     = 4'hA;
  localparam logic [3:0] ADDR_CNT_LO   = 4'hB;
  localparam logic [3:0] ADDR_CNT_HI   = 4'hC;

  // Bit positions shared by mask and flag registers
  localparam int BIT_CAP  = 5;
  localparam int BIT_CMPC = 3;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CMPA = 1;
  localparam int BIT_OVF  = 0;
  localparam logic [7:0] FLAG_USED = 8'h2F;

  // Control register fields
  localparam int CTRL_FILT = 7;
  localparam int CTRL_EDGE = 6;
  localparam int CTRL_ACMP = 5;
  localparam int CTRL_WGM  = 0;

  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam int          FILT_LEN  = 4;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_BOT   = 16'h0000;

  // Overflow point for each waveform mode
  typedef enum logic [1:0] {
    OVF_AT_MAX    = 2'h0,
    OVF_AT_TOP    = 2'h1,
    OVF_AT_BOTTOM = 2'h2,
    OVF_NONE      = 2'h3
  } tcc_ovf_t;

  // Ceiling source for each waveform mode
  typedef enum logic [1:0] {
    TOP_FIXED = 2'h0,
    TOP_CMPA  = 2'h1,
    TOP_CAP   = 2'h2
  } tcc_top_t;

  function automatic tcc_ovf_t tcc_ovf_point(input logic [3:0] wgm);
    case (wgm)
      4'h0, 4'h4, 4'hC: tcc_ovf_point = OVF_AT_MAX;
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: tcc_ovf_point = OVF_AT_BOTTOM;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: tcc_ovf_point = OVF_AT_TOP;
      default: tcc_ovf_point = OVF_NONE;
    endcase
  endfunction

  function automatic tcc_top_t tcc_top_src(input logic [3:0] wgm);
    case (wgm)
      4'h8, 4'hA, 4'hC, 4'hE: tcc_top_src = TOP_CAP;
      4'h4, 4'h9, 4'hB, 4'hF: tcc_top_src = TOP_CMPA;
      default: tcc_top_src = TOP_FIXED;
    endcase
  endfunction

  function automatic logic [15:0] tcc_top_value(input logic [3:0] wgm);
    case (wgm)
      4'h1, 4'h9: tcc_top_value = 16'h00FF;
      4'h2, 4'hA: tcc_top_value = 16'h01FF;
      4'h3, 4'hB: tcc_top_value = 16'h03FF;
      4'h5: tcc_top_value = 16'h00FF;
      4'h6: tcc_top_value = 16'h01FF;
      4'h7: tcc_top_value = 16'h03FF;
      default: tcc_top_value = CNT_MAX;
    endcase
  endfunction
endpackage

// File: rtl/tcc_capture_filter.sv
// Capture pin noise filter and edge detector
`timescale 1ns/1ps
module tcc_capture_filter
  import tcc_pkg::*;
#(
  parameter int LEN = FILT_LEN
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic filt_en,
  input  wire logic rise_sel,
  // Pin and event
  input  wire logic pin,
  output logic      event_pulse
);
  initial begin
    if (LEN < 2 || LEN > 8) $error("tcc_capture_filter: LEN out of range");
  end

  typedef struct packed {
    logic [LEN-1:0] hist;
    logic           level;
    logic           prev;
    logic           ev;
  } tcc_flt_st_t;

  tcc_flt_st_t st_r;
  tcc_flt_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.hist = {st_r.hist[LEN-2:0], pin};
    // With the filter on, the filtered level moves only after LEN equal samples
    if (!filt_en) begin
      st_nxt.level = pin;
    end else if (&st_r.hist) begin // [RQ17]
      st_nxt.level = 1'b1;
    end else if (~|st_r.hist) begin // [RQ17]
      st_nxt.level = 1'b0;
    end
    st_nxt.prev = st_r.level;
    st_nxt.ev = rise_sel ? (st_r.level & ~st_r.prev) : (~st_r.level & st_r.prev); // [RQ16]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign event_pulse = st_r.ev;
endmodule

// File: tb/tcc_timer16_checker.sv
// Port-level assertions for the timer compare/capture block
`timescale 1ns/1ps
module tcc_timer16_checker
  import tcc_pkg::*;
#(
  parameter int FILTER_LEN = FILT_LEN
) (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RESET,
  // Register port
  input wire logic [3:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  // Counter core
  input wire logic [15:0] COUNTER_VALUE,
  input wire logic        TIMER_TICK,
  input wire logic        COUNT_DOWN,
  input wire logic [2:0]  FORCE_COMPARE_STROBE,
  input wire logic [3:0]  WAVEFORM_MODE_SELECT,
  input wire logic [15:0] COUNTER_WRITE_VALUE,
  input wire logic        COUNTER_WRITE,
  input wire logic [15:0] TOP_VALUE,
  input wire logic [2:0]  COMPARE_MATCH,
  input wire logic [2:0]  COMPARE_FORCE,
  // Capture sources
  input wire logic        CAPTURE_PIN,
  input wire logic        COMPARATOR_OUT,
  // Interrupt handshake
  input wire logic        GLOBAL_IRQ_ENABLE,
  input wire logic [4:0]  VECTOR_ACK,
  input wire logic [4:0]  IRQ_REQUEST
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  property p_match_tick; |COMPARE_MATCH |-> $past(TIMER_TICK); endproperty
  a_match_tick: assert property (p_match_tick) else $error("match without tick");
  property p_force_quiet; (FORCE_COMPARE_STROBE != 3'h0) && !TIMER_TICK |=> COMPARE_MATCH == 3'h0;
  endproperty
  a_force_quiet: assert property (p_force_quiet) else $error("force made a match");
  property p_latch;
    WR && ADDR == ADDR_CNT_HI ##1 WR && ADDR == ADDR_CNT_LO
      |=> COUNTER_WRITE && COUNTER_WRITE_VALUE == {$past(WDATA, 2), $past(WDATA)};
  endproperty
  a_latch: assert property (p_latch) else $error("counter commit wrong");
  property p_block; COUNTER_WRITE |=> COMPARE_MATCH == 3'h0; endproperty
  a_block: assert property (p_block) else $error("match after counter write");
  property p_cap_gate; IRQ_REQUEST[4] |-> $past(GLOBAL_IRQ_ENABLE); endproperty
  a_cap_gate: assert property (p_cap_gate) else $error("capture request ungated");
  property p_cmp_gate; $fell(GLOBAL_IRQ_ENABLE) |=> IRQ_REQUEST[3:1] == 3'h0; endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare request ungated");
  property p_ovf_gate; !GLOBAL_IRQ_ENABLE |=> !IRQ_REQUEST[0]; endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request ungated");
  // No tick in the ack cycle, so no new overflow can beat the clear
  property p_ack; VECTOR_ACK[0] && !TIMER_TICK |=> ##1 !IRQ_REQUEST[0]; endproperty
  a_ack: assert property (p_ack) else $error("ack left overflow pending");

  c_match: cover property (COMPARE_MATCH[0]);
  c_cap: cover property (IRQ_REQUEST[4]);
  c_load: cover property (COUNTER_WRITE);
endmodule

bind tcc_timer16 tcc_timer16_checker #(.FILTER_LEN(FILTER_LEN)) u_checker (
  .CLOCK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .COUNTER_VALUE, .TIMER_TICK,
  .COUNT_DOWN, .FORCE_COMPARE_STROBE, .WAVEFORM_MODE_SELECT, .COUNTER_WRITE_VALUE,
  .COUNTER_WRITE, .TOP_VALUE, .COMPARE_MATCH, .COMPARE_FORCE, .CAPTURE_PIN,
  .COMPARATOR_OUT, .GLOBAL_IRQ_ENABLE, .VECTOR_ACK, .IRQ_REQUEST
);

// File: tb/tcc_core_model.sv
// Counter core stand-in: counts on enabled cycles, loads on CPU writes
`timescale 1ns/1ps
module tcc_core_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Controls
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic        down,
  input  wire logic [15:0] load_val,
  // Counter outputs
  output logic      [15:0] cnt,
  output logic             tick
);
  // Bench paces the timer clock, so stalls and bursts are both possible
  assign tick = run;
  always_ff @(posedge clk) begin
    if (rst)
      cnt <= 16'h0000;
    else if (load)
      cnt <= load_val;
    else if (tick)
      cnt <= down ? cnt - 16'h0001 : cnt + 16'h0001;
  end
endmodule

// File: tb/test_tcc_timer16.sv
// Self-checking bench for the timer compare/capture register block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module test_tcc_timer16
  import tcc_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        run = 1'b0;
  logic        cap_pin = 1'b0;
  logic        gie = 1'b0;
  logic [2:0]  force_stb = 3'h0;
  logic [4:0]  ack = 5'h00;
  logic        cdown = 1'b0;
  logic        cmp_out = 1'b0;
  logic [3:0]  wgm;
  logic [15:0] top_val;
  logic [2:0]  cmp_force;
  logic [7:0]  rdata;
  logic [15:0] cnt;
  logic        tick;
  logic        cnt_wr;
  logic [15:0] cnt_wr_val;
  logic [4:0]  irq;
  logic [7:0]  d;
  int          error_cnt = 0;
  int          n_tests = 0;

  initial begin
    forever #25 clock = ~clock;
  end

  tcc_timer16 #(.FILTER_LEN(FILT_LEN)) dut (
    .CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .COUNTER_VALUE(cnt), .TIMER_TICK(tick), .COUNT_DOWN(cdown), .FORCE_COMPARE_STROBE(force_stb),
    .WAVEFORM_MODE_SELECT(wgm), .COUNTER_WRITE_VALUE(cnt_wr_val), .COUNTER_WRITE(cnt_wr),
    .TOP_VALUE(top_val), .COMPARE_MATCH(), .COMPARE_FORCE(cmp_force), .CAPTURE_PIN(cap_pin),
    .COMPARATOR_OUT(cmp_out), .GLOBAL_IRQ_ENABLE(gie), .VECTOR_ACK(ack), .IRQ_REQUEST(irq)
  );
  tcc_core_model core (.clk(clock), .rst(reset), .run(run), .load(cnt_wr), .down(cdown),
    .load_val(cnt_wr_val), .cnt(cnt), .tick(tick));

  // Strobes stay up on return so back-to-back calls give one access per clock
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    rd    <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    wr   <= 1'b0;
    rd   <= 1'b1;
    @(posedge clock);
    #1 v = rdata;
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr_reg(a + 4'h1, v[15:8]);
    wr_reg(a, v[7:0]);
  endtask
  task automatic set_cnt(input logic [15:0] v);
    wr16(ADDR_CNT_LO, v);
    idle(3);
  endtask
  task automatic chk_rd(input string nm, input logic [3:0] a, input logic [7:0] e);
    rd_reg(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic chk_irq(input string nm, input logic [4:0] e);
    #1;
    `CHK(nm, e, irq)
  endtask
  task automatic pin_to(input logic v, input int n);
    cap_pin <= v;
    idle(n);
  endtask
  task automatic run_for(input int n);
    run <= 1'b1;
    idle(n);
    run <= 1'b0;
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 13; a++) chk_rd("reset", a[3:0], RST_BYTE);
    chk_rd("unmapped", 4'hF, 8'h00);
    // Second high byte overwrites the one shared staging byte
    wr_reg(ADDR_CMPA_HI, 8'h12);
    wr_reg(ADDR_CMPB_HI, 8'h56);
    wr_reg(ADDR_CMPA_LO, 8'h34);
    chk_rd("cmpa lo", ADDR_CMPA_LO, 8'h34);
    chk_rd("cmpa hi", ADDR_CMPA_HI, 8'h56);
    for (int c = 0; c < 3; c++) wr16(ADDR_CMPA_LO + 4'(2 * c), 16'h0020 + 16'(8 * c));
    set_cnt(16'h0000);
    run_for(32);
    chk_rd("edge of match", ADDR_FLAGS, 8'h00);
    run_for(40);
    chk_rd("cmp flags", ADDR_FLAGS, 8'h0E);
    wr_reg(ADDR_MASK, 8'h2F);
    gie <= 1'b1;
    idle(3);
    chk_irq("irq cmp", 5'h0E);
    gie <= 1'b0;
    idle(2);
    chk_irq("irq off", 5'h00);
    gie <= 1'b1;
    ack <= 5'h02;
    idle(1);
    ack <= 5'h00;
    idle(3);
    chk_irq("irq ack", 5'h0C);
    wr_reg(ADDR_FLAGS, 8'h04);
    chk_rd("w1c", ADDR_FLAGS, 8'h08);
    wr_reg(ADDR_FLAGS, 8'h00);
    chk_rd("w0", ADDR_FLAGS, 8'h08);
    wr_reg(ADDR_FLAGS, 8'hFF);
    wr16(ADDR_CMPA_LO, 16'h0100);
    set_cnt(16'h0100);
    run_for(4);
    chk_rd("blocked", ADDR_FLAGS, 8'h00);
    set_cnt(16'hFFF0);
    run_for(20);
    chk_rd("ovf", ADDR_FLAGS, 8'h01);
    chk_irq("irq ovf", 5'h01);
    ack <= 5'h01;
    idle(1);
    ack <= 5'h00;
    idle(3);
    chk_irq("ovf ack", 5'h00);
    force_stb <= 3'h7;
    idle(1);
    force_stb <= 3'h0;
    #1 `CHK("force out", 3'h7, cmp_force)
    idle(3);
    chk_rd("force", ADDR_FLAGS, 8'h00);
    set_cnt(16'hBEEF);
    wr_reg(ADDR_CTRL, 8'h40);
    pin_to(1'b1, 8);
    chk_rd("cap flag", ADDR_FLAGS, 8'h20);
    chk_irq("irq cap", 5'h10);
    set_cnt(16'h1234);
    pin_to(1'b0, 8);
    chk_rd("cap lo", ADDR_CAP_LO, 8'hEF);
    chk_rd("cap hi", ADDR_CAP_HI, 8'hBE);
    wr_reg(ADDR_CTRL, 8'h00);
    pin_to(1'b1, 8);
    pin_to(1'b0, 8);
    chk_rd("cap fall", ADDR_CAP_LO, 8'h34);
    wr_reg(ADDR_FLAGS, 8'hFF);
    wr_reg(ADDR_CTRL, 8'hC0);
    pin_to(1'b1, 3);
    pin_to(1'b0, 10);
    chk_rd("glitch", ADDR_FLAGS, 8'h00);
    pin_to(1'b1, 12);
    chk_rd("filtered", ADDR_FLAGS, 8'h20);
    // Capture as ceiling: pin edges ignored, flag on counter reaching it
    wr_reg(ADDR_FLAGS, 8'hFF);
    wr16(ADDR_CAP_LO, 16'h0040);
    wr_reg(ADDR_CTRL, 8'h4C);
    pin_to(1'b0, 8);
    pin_to(1'b1, 8);
    chk_rd("cap off", ADDR_FLAGS, 8'h00);
    chk_rd("cap kept", ADDR_CAP_LO, 8'h40);
    set_cnt(16'h003C);
    run_for(6);
    chk_rd("cap top", ADDR_FLAGS, 8'h20);
    `CHK("top cap", 16'h0040, top_val)
    // Fast PWM with fixed ceiling: overflow at the ceiling, force ignored
    wr_reg(ADDR_FLAGS, 8'hFF);
    wr_reg(ADDR_CTRL, 8'h05);
    set_cnt(16'h00F8);
    run_for(8);
    chk_rd("pwm ovf", ADDR_FLAGS, 8'h01);
    `CHK("mode", 4'h5, wgm)
    `CHK("top fix", 16'h00FF, top_val)
    force_stb <= 3'h7;
    idle(1);
    force_stb <= 3'h0;
    #1 `CHK("pwm force", 3'h0, cmp_force)
    // Phase correct: overflow at bottom while counting down
    wr_reg(ADDR_FLAGS, 8'hFF);
    wr_reg(ADDR_CTRL, 8'h01);
    set_cnt(16'h0002);
    cdown <= 1'b1;
    run_for(3);
    cdown <= 1'b0;
    chk_rd("bottom", ADDR_FLAGS, 8'h01);
    // Comparator as capture source
    wr_reg(ADDR_FLAGS, 8'hFF);
    wr_reg(ADDR_CTRL, 8'h60);
    set_cnt(16'h0ABC);
    chk_rd("cnt lo", ADDR_CNT_LO, 8'hBC);
    chk_rd("cnt hi", ADDR_CNT_HI, 8'h0A);
    cmp_out <= 1'b1;
    idle(8);
    chk_rd("acmp lo", ADDR_CAP_LO, 8'hBC);
    chk_rd("acmp flag", ADDR_FLAGS, 8'h20);
    idle(2);
    complete_run();
  end
endmodule
